// ---- design/wdcm_watchdog.v ----
// wdcm_watchdog.v: windowed watchdog with instruction-clock monitor
// assumes: idleTick pulses once per idle-timer clock, instrTick once per
// instruction cycle, inputs other than arst_n and wdPinIn synchronous to clk; the open pin is
// resolved outside from wdPinOe (low while enabled) and a weak pull-up
`timescale 1ns/1ps
`default_nettype none
`include "wdcm_regs.vh"

// Functional notes
// - lower window limit fixed at 2048 idle-timer clocks; earlier service is refused.
// - bits 7:6 select upper limit 8k, 16k, 32k or 64k clocks.
// - bits 5:1 must always carry key 01100.
// - bit 0 enables the clock monitor, independent of window select.
// - all window counting advances on idle-timer clocks only.
// - watchdog runs only while option bit 2 is 0; pin becomes output.
// - inactive in reset; afterwards armed, window 11, monitor enabled.
// - one keyed configuring write after reset fixes window and monitor enable.
// - later writes compare all fields; full match restarts the window.
// - any field mismatch on a service write raises the output.
// - no valid service before the upper limit raises an error.
// - a service inside the lower limit raises an error.
// - boot ROM entry services immediately and suppresses the lower error.
// - output active low, only pulled low, never driven high.
// - keep pulling 16 to 32 cycles after pin seen low, then release.
// - window restarts from zero when the pin returns high after an error.
// - service writes while a watchdog error is active are ignored.
// - pin low at power-up still times out and then releases.
// - enabled monitor holds pin low on slow clock, releases 16 later.
// - never flag tick rates above 5 kHz, always flag below 10 Hz.
// - monitor enabled from reset flags an oscillator that never starts.
// - watchdog inhibited in halt and idle; monitor stays active.
// - leaving idle mode performs a hardware service.
// - reads return zeros in the key field.
module wdcm_watchdog #(
  parameter integer MON_LIMIT = `WDCM_MON_CYCLES
) (
  input  wire       clk,
  input  wire       arst_n,
  input  wire       wdOptionDisable,
  input  wire       idleTick,
  input  wire       instrTick,
  input  wire       haltMode,
  input  wire       idleMode,
  input  wire       bootRomActive,
  input  wire       svcWrite,
  input  wire [7:0] svcWdata,
  output reg  [7:0] svcRdata,
  input  wire       wdPinIn,
  output reg        wdPinOut,
  output reg        wdPinOe,
  output reg        wdErrorActive
);

  localparam [1:0] ST_ARMED   = 2'h0;
  localparam [1:0] ST_PULL    = 2'h1;
  localparam [1:0] ST_HOLD    = 2'h2;
  localparam [1:0] ST_RELEASE = 2'h3;

  // cut to the counter width on purpose; MON_LIMIT stays below 2^23
  localparam integer MON_LAST_INT = MON_LIMIT - 1;
  localparam [22:0]  MON_LAST     = MON_LAST_INT[22:0];

  function [16:0] upperLimit;
    input [1:0] sel;
    begin
      upperLimit = `WDCM_UPPER_BASE << sel;
    end
  endfunction

  function keyOk;
    input [7:0] data;
    begin
      keyOk = (data[`WDCM_KEY_MSB:`WDCM_KEY_LSB] == `WDCM_KEY_VALUE);
    end
  endfunction

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [16:0] winCnt;
  reg  [16:0] next_winCnt;
  reg  [4:0]  holdCnt;
  reg  [4:0]  next_holdCnt;
  reg  [1:0]  winSel;
  reg         monEnable;
  reg         configured;
  reg         next_configured;
  reg         takeConfig;
  reg         pinSync1;
  reg         pinSync2;
  reg         idlePrev;
  reg         bootPrev;
  reg  [22:0] gapCnt;
  reg  [4:0]  goodCnt;
  reg         clkBad;

  wire        wdActive  = ~wdOptionDisable;
  wire        inhibit   = haltMode | idleMode;
  wire        hwService = (idlePrev & ~idleMode) | (bootRomActive & ~bootPrev);
  wire [16:0] upper     = upperLimit(winSel);
  wire        fieldsOk  = keyOk(svcWdata) &&
                          (svcWdata[`WDCM_WIN_MSB:`WDCM_WIN_LSB] == winSel) &&
                          (svcWdata[`WDCM_MON_BIT] == monEnable);
  wire        tooEarly  = (winCnt < `WDCM_LOWER_LIMIT) & ~bootRomActive;
  wire        pinLow    = ~pinSync2;

  // two-stage synchroniser on the pin; only pinSync2 is used
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinSync1 <= 1'b1;
      pinSync2 <= 1'b1;
    end else begin
      pinSync1 <= wdPinIn;
      pinSync2 <= pinSync1;
    end
  end

  // window and pulse sequencing
  always @* begin
    next_state      = state;
    next_winCnt     = winCnt;
    next_holdCnt    = holdCnt;
    next_configured = configured;
    takeConfig      = 1'b0;
    if (!wdActive) begin
      next_state  = ST_ARMED;
      next_winCnt = 17'h00000;
    end else begin
      case (state)
        ST_ARMED: begin
          if (hwService) begin
            next_winCnt = 17'h00000;
          end else if (svcWrite && !inhibit) begin
            // writes in halt or idle neither service nor fault
            if (!configured) begin
              // first window after reset has no lower limit
              if (keyOk(svcWdata)) begin
                takeConfig      = 1'b1;
                next_configured = 1'b1;
                next_winCnt     = 17'h00000;
              end else begin
                next_state = ST_PULL;
              end
            end else if (!fieldsOk) begin
              next_state = ST_PULL;
            end else if (tooEarly) begin
              next_state = ST_PULL;
            end else begin
              next_winCnt = 17'h00000;
            end
          end else if (!inhibit && idleTick) begin
            // counting is frozen in halt and idle
            if (winCnt + 17'h00001 >= upper) begin
              next_state = ST_PULL;
            end else begin
              next_winCnt = winCnt + 17'h00001;
            end
          end
        end
        ST_PULL: begin
          // writes here are ignored
          if (pinLow) begin
            next_state   = ST_HOLD;
            next_holdCnt = 5'h00;
          end
        end
        ST_HOLD: begin
          if (holdCnt == `WDCM_HOLD_CYCLES - 5'h01) begin
            next_state = ST_RELEASE;
          end else begin
            next_holdCnt = holdCnt + 5'h01;
          end
        end
        ST_RELEASE: begin
          // pin may stay low while the monitor still pulls it
          if (!pinLow) begin
            next_state  = ST_ARMED;
            next_winCnt = 17'h00000;
          end
        end
        default: begin
          next_state = ST_ARMED;
        end
      endcase
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= ST_ARMED;
      winCnt     <= 17'h00000;
      holdCnt    <= 5'h00;
      configured <= 1'b0;
      winSel     <= `WDCM_WIN_RESET;
      monEnable  <= `WDCM_MON_RESET;
      idlePrev   <= 1'b0;
      bootPrev   <= 1'b0;
    end else begin
      state      <= next_state;
      winCnt     <= next_winCnt;
      holdCnt    <= next_holdCnt;
      configured <= next_configured;
      idlePrev   <= idleMode;
      bootPrev   <= bootRomActive;
      if (takeConfig) begin
        winSel    <= svcWdata[`WDCM_WIN_MSB:`WDCM_WIN_LSB];
        monEnable <= svcWdata[`WDCM_MON_BIT];
      end
    end
  end

  // clock monitor: measures clk cycles between instruction ticks.
  // a fixed 1 ms gap sits well between the 200 us and 100 ms bounds,
  // trading sensitivity for margin against jitter
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gapCnt  <= 23'h000000;
      goodCnt <= 5'h00;
      clkBad  <= 1'b0;
    end else begin
      if (instrTick) begin
        gapCnt <= 23'h000000;
        if (clkBad) begin
          if (goodCnt == `WDCM_MON_RECOVER - 5'h01) begin
            clkBad  <= 1'b0;
            goodCnt <= 5'h00;
          end else begin
            goodCnt <= goodCnt + 5'h01;
          end
        end
      end else if (gapCnt == MON_LAST) begin
        clkBad  <= 1'b1;
        goodCnt <= 5'h00;
      end else begin
        gapCnt <= gapCnt + 23'h000001;
      end
    end
  end

  // registered outputs; the pin is only ever pulled low
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wdPinOut      <= 1'b0;
      wdPinOe       <= 1'b0;
      wdErrorActive <= 1'b0;
      svcRdata      <= 8'h00;
    end else begin
      wdPinOut      <= 1'b0;
      wdPinOe       <= wdActive &
                       ((next_state == ST_PULL) | (next_state == ST_HOLD) |
                        (monEnable & clkBad));
      wdErrorActive <= wdActive & (next_state != ST_ARMED);
      svcRdata      <= {winSel, `WDCM_KEY_READ, monEnable};
    end
  end

endmodule // wdcm_watchdog
`default_nettype wire

// ---- design/wdcm_regs.vh ----
// wdcm_regs.vh: constants for the windowed watchdog and clock monitor
// assumes: included by design/wdcm_watchdog.v only; definitions only
`ifndef WDCM_REGS_VH
`define WDCM_REGS_VH

// service register field layout
`define WDCM_WIN_MSB        7
`define WDCM_WIN_LSB        6
`define WDCM_KEY_MSB        5
`define WDCM_KEY_LSB        1
`define WDCM_MON_BIT        0
`define WDCM_KEY_VALUE      5'h0C
`define WDCM_KEY_READ       5'h00

// reset values of the stored fields
`define WDCM_WIN_RESET      2'h3
`define WDCM_MON_RESET      1'h1

// window limits in idle-timer clocks
`define WDCM_LOWER_LIMIT    17'h00800
`define WDCM_UPPER_BASE     17'h02000

// clock monitor: a tick gap longer than this flags a slow clock
`define WDCM_CLK_MHZ        40
`define WDCM_MON_TIMEOUT_US 1000
`define WDCM_MON_CYCLES     (`WDCM_MON_TIMEOUT_US * `WDCM_CLK_MHZ)
// good instruction ticks needed before the monitor lets go
`define WDCM_MON_RECOVER    5'h10

// low-pulse stretch after the pin is seen low, in clk cycles (16 to 32)
`define WDCM_HOLD_CYCLES    5'h18

`endif

// ---- test/wdcm_watchdog_properties.sv ----
// wdcm_watchdog_properties.sv: port checker for the watchdog
// assumes: bound to wdcm_watchdog; pin level comes from a pull-up model
`timescale 1ns/1ps
`default_nettype none
module wdcm_watchdog_properties #(
  parameter integer MON_LIMIT = 40000
) (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       wdOptionDisable,
  input wire logic       idleTick,
  input wire logic       instrTick,
  input wire logic       haltMode,
  input wire logic       idleMode,
  input wire logic       bootRomActive,
  input wire logic       svcWrite,
  input wire logic [7:0] svcWdata,
  input wire logic [7:0] svcRdata,
  input wire logic       wdPinIn,
  input wire logic       wdPinOut,
  input wire logic       wdPinOe,
  input wire logic       wdErrorActive
);
  logic [31:0] gap;
  wire quiet = !wdErrorActive && !wdOptionDisable && !haltMode && !idleMode;
  // saturating gap counter, so a long stall cannot wrap
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) gap <= 32'h0;
    else if (instrTick) gap <= 32'h0;
    else if (gap < MON_LIMIT) gap <= gap + 32'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_pin_fell;
    $fell(wdPinIn) && wdErrorActive;
  endsequence
  sequence s_held16;
    wdPinOe [*8] ##1 wdPinOe [*8];
  endsequence
  a_never_high: assert property (wdPinOut == 1'b0)
    else $error("pin driven high");
  a_bad_key: assert property (quiet && !bootRomActive && svcWrite && svcWdata[5:1] != 5'h0C |=> wdPinOe)
    else $error("bad key not flagged");
  a_option_off: assert property (wdOptionDisable ##1 wdOptionDisable |-> !wdPinOe && !wdErrorActive)
    else $error("disabled watchdog active");
  a_hold_low: assert property (s_pin_fell |-> s_held16)
    else $error("low pulse too short");
  a_release_bound: assert property (s_pin_fell |-> ##[16:40] !wdPinOe)
    else $error("pin not released");
  a_key_hidden: assert property (svcRdata[5:1] == 5'h00)
    else $error("key readable");
  a_flag_pulls: assert property ($rose(wdErrorActive) |-> wdPinOe)
    else $error("error without pull");
  a_slow_clock: assert property (gap == MON_LIMIT && svcRdata[0] && !wdOptionDisable |-> ##[0:3] wdPinOe)
    else $error("slow clock not flagged");
  a_frozen_modes: assert property ((haltMode || idleMode) && svcWrite && !wdErrorActive |=> !wdErrorActive)
    else $error("error in power save");
  a_boot_exempt: assert property (bootRomActive && svcWrite && quiet
      && svcWdata == {svcRdata[7:6], 5'h0C, svcRdata[0]} |=> !wdErrorActive)
    else $error("boot service flagged");
endmodule // wdcm_watchdog_properties
bind wdcm_watchdog wdcm_watchdog_properties #(.MON_LIMIT(MON_LIMIT)) u_props (.clk(clk), .arst_n(arst_n),
  .wdOptionDisable(wdOptionDisable), .idleTick(idleTick), .instrTick(instrTick), .haltMode(haltMode),
  .idleMode(idleMode), .bootRomActive(bootRomActive), .svcWrite(svcWrite), .svcWdata(svcWdata),
  .svcRdata(svcRdata), .wdPinIn(wdPinIn), .wdPinOut(wdPinOut), .wdPinOe(wdPinOe), .wdErrorActive(wdErrorActive));
`default_nettype wire

// ---- test/wdcm_pin_partner.sv ----
// wdcm_pin_partner.sv: open pin with weak pull-up toward system reset
// assumes: the watchdog only ever pulls low through its enable
`timescale 1ns/1ps
`default_nettype none
module wdcm_pin_partner (
  input  wire logic drvOe,
  input  wire logic drvOut,
  output wire logic pinLevel
);
  // pull-up holds high unless pulled low
  assign pinLevel = (drvOe && !drvOut) ? 1'b0 : 1'b1;
endmodule // wdcm_pin_partner
`default_nettype wire

// ---- test/windowed_watchdog_clock_monitor_tb_top.sv ----
// windowed_watchdog_clock_monitor_tb_top.sv: self-checking watchdog bench
// assumes: one idle-timer clock per clk cycle, short monitor limit
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_clock_monitor_tb_top;
  localparam integer MONL = 200;
  logic       clk, arst_n, optOff, idleTick, instrTick, halt, idle, boot, svcWrite, runInstr;
  logic [7:0] svcWdata, rdata;
  logic [2:0] phase;
  logic       pinOut, pinOe, errAct;
  wire        pinIn;
  integer     num_errors, samples_checked, n, i;
  wdcm_watchdog #(.MON_LIMIT(MONL)) dut (.clk(clk), .arst_n(arst_n), .wdOptionDisable(optOff),
    .idleTick(idleTick), .instrTick(instrTick), .haltMode(halt), .idleMode(idle), .bootRomActive(boot),
    .svcWrite(svcWrite), .svcWdata(svcWdata), .svcRdata(rdata), .wdPinIn(pinIn), .wdPinOut(pinOut),
    .wdPinOe(pinOe), .wdErrorActive(errAct));
  wdcm_pin_partner u_pin (.drvOe(pinOe), .drvOut(pinOut), .pinLevel(pinIn));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // instruction tick every 8 cycles, well inside the monitor limit
  always @(negedge clk) begin
    phase <= phase + 3'h1;
    instrTick <= runInstr && (phase == 3'h0);
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    svcWrite = 1'b1;
    svcWdata = d;
    @(negedge clk);
    svcWrite = 1'b0;
    @(negedge clk);
  endtask
  task automatic wait_err(input logic v, input integer lim);
    n = 0;
    while (errAct !== v) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        chk("error flag wait", {7'h0, v}, {7'h0, errAct});
        end_sim;
      end
    end
  endtask
  task automatic t_first_write;
    chk("reset readback", 8'hC1, rdata);
    wr(8'hC3);
    chk("pull on bad key", 8'h01, {7'h0, pinOe});
    wait_err(1'b0, 200);
    chk("pulse length ok", 8'h01, {7'h0, n >= 18 && n <= 45});
    wr(8'h19);
    chk("config exempt", 8'h00, {7'h0, pinOe});
    @(negedge clk);
    chk("config readback", 8'h01, rdata);
    wr(8'h19);
    chk("early service", 8'h01, {7'h0, pinOe});
    wait_err(1'b0, 200);
  endtask
  task automatic t_services;
    repeat (2100) @(negedge clk);
    wr(8'h19);
    chk("valid service", 8'h00, {7'h0, pinOe});
    boot = 1'b1;
    @(negedge clk);
    wr(8'h19);
    chk("boot service", 8'h00, {7'h0, pinOe});
    boot = 1'b0;
    repeat (2100) @(negedge clk);
    halt = 1'b1;
    wr(8'hC3);
    halt = 1'b0;
    idle = 1'b1;
    wr(8'hC3);
    chk("frozen in power save", 8'h00, {7'h0, pinOe});
    idle = 1'b0;
    @(negedge clk);
    wr(8'h19);
    chk("idle exit restarts", 8'h01, {7'h0, pinOe});
    wait_err(1'b0, 200);
    for (i = 0; i < 2; i++) begin
      wr(i == 0 ? 8'h59 : 8'h18);
      chk("field mismatch", 8'h01, {7'h0, pinOe});
      wait_err(1'b0, 200);
    end
  endtask
  task automatic t_timeout;
    wait_err(1'b1, 9000);
    chk("upper limit 8k", 8'h01, {7'h0, n >= 8186 && n <= 8196});
    wait_err(1'b0, 200);
    runInstr = 1'b0;
    n = 0;
    while (pinOe !== 1'b1 && n < MONL + 20) begin
      @(negedge clk);
      n++;
    end
    chk("slow clock pull", 8'h01, {7'h0, pinOe === 1'b1 && n >= MONL - 10});
    if (pinOe !== 1'b1) end_sim;
    runInstr = 1'b1;
    repeat (16 * 8 + 80) @(negedge clk);
    chk("clock recovered", 8'h00, {7'h0, pinOe});
    optOff = 1'b1;
    repeat (2) @(negedge clk);
    wr(8'hC3);
    chk("option off", 8'h00, {7'h0, pinOe});
  endtask
  task automatic t_reset_again;
    arst_n = 1'b0;
    optOff = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    chk("second reset readback", 8'hC1, rdata);
    wr(8'h58);
    @(negedge clk);
    chk("monitor off readback", 8'h40, rdata);
    runInstr = 1'b0;
    repeat (MONL + 20) @(negedge clk);
    chk("monitor disabled", 8'h00, {7'h0, pinOe});
    runInstr = 1'b1;
    wait_err(1'b1, 17000);
    chk("upper limit 16k", 8'h01, {7'h0, n >= 16100 && n <= 16390});
    wait_err(1'b0, 200);
  endtask
  initial begin
    {arst_n, optOff, halt, idle, boot, svcWrite, instrTick} = 7'h00;
    {idleTick, runInstr, phase, svcWdata} = 13'h1800;
    num_errors = 0;
    samples_checked = 0;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    t_first_write;
    t_services;
    t_timeout;
    t_reset_again;
    end_sim;
  end
endmodule // windowed_watchdog_clock_monitor_tb_top
`default_nettype wire
